// [logic/tmr8_pkg.sv]
package tmr8_pkg;

   // register byte offsets
   localparam logic [7:0] TMR8_OFS_CTRL_A = 8'h00;
   localparam logic [7:0] TMR8_OFS_CTRL_B = 8'h04;
   localparam logic [7:0] TMR8_OFS_COUNT  = 8'h08;
   localparam logic [7:0] TMR8_OFS_CMP_A  = 8'h0C;
   localparam logic [7:0] TMR8_OFS_CMP_B  = 8'h10;
   localparam logic [7:0] TMR8_OFS_FLAGS  = 8'h14;

   // field positions and masks
   localparam int         TMR8_CHA_ACT_LSB  = 6;
   localparam int         TMR8_CHB_ACT_LSB  = 4;
   localparam int         TMR8_WGM_LOW_LSB  = 0;
   localparam logic [7:0] TMR8_CTRL_A_WMASK = 8'hF3;
   localparam int         TMR8_WGM_TOP_BIT  = 3;
   localparam int         TMR8_RUN_BIT      = 0;
   localparam int         TMR8_ASYNC_BIT    = 1;
   localparam logic [7:0] TMR8_CTRL_B_WMASK = 8'h0B;
   localparam int         TMR8_FLAG_OVF     = 0;
   localparam int         TMR8_FLAG_MATCH_A = 1;
   localparam int         TMR8_FLAG_MATCH_B = 2;

   // reset values and counter limits
   localparam logic [7:0] TMR8_RESET_8 = 8'h00;
   localparam logic [7:0] TMR8_MAX     = 8'hFF;
   localparam logic [7:0] TMR8_BOTTOM  = 8'h00;
   localparam logic [2:0] TMR8_HSIZE_WORD = 3'h2;

   // output action encodings
   localparam logic [1:0] TMR8_ACT_OFF    = 2'h0;
   localparam logic [1:0] TMR8_ACT_TOGGLE = 2'h1;

   typedef enum logic [2:0] {
      TMR8_MODE_NORMAL   = 3'h0,
      TMR8_MODE_PC_MAX   = 3'h1,
      TMR8_MODE_CLR_CMP  = 3'h2,
      TMR8_MODE_FAST_MAX = 3'h3,
      TMR8_MODE_RSVD4    = 3'h4,
      TMR8_MODE_PC_CMP   = 3'h5,
      TMR8_MODE_RSVD6    = 3'h6,
      TMR8_MODE_FAST_CMP = 3'h7
   } tmr8_mode_t;

   typedef enum logic {
      TMR8_DIR_UP   = 1'b0,
      TMR8_DIR_DOWN = 1'b1
   } tmr8_dir_t;

endpackage

// [logic/tmr8_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr8_sync2
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic async_in,
   output var  logic sync_out
);
   logic meta_reg;
   logic meta_next;
   logic sync_next;

   always_comb
   begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_out <= sync_next;
      end
   end
endmodule // tmr8_sync2
`default_nettype wire

// [logic/tmr8_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr8_top
   import tmr8_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic [31:0] hrdata,
   output var  logic        hresp,
   input  wire logic        timer_osc_in,
   output var  logic        channel_a_wave_out,
   output var  logic        channel_a_wave_oe,
   output var  logic        channel_b_wave_out,
   output var  logic        channel_b_wave_oe
);
   ////////////////////////////////////////////////////////////////////////////////////
   logic [7:0]  ctrl_a_reg;
   logic [7:0]  ctrl_a_next;
   logic [7:0]  ctrl_b_reg;
   logic [7:0]  ctrl_b_next;
   logic [7:0]  count_reg;
   logic [7:0]  count_next;
   logic [7:0]  cmp_a_buf_reg;
   logic [7:0]  cmp_a_buf_next;
   logic [7:0]  cmp_b_buf_reg;
   logic [7:0]  cmp_b_buf_next;
   logic [7:0]  cmp_a_reg;
   logic [7:0]  cmp_a_next;
   logic [7:0]  cmp_b_reg;
   logic [7:0]  cmp_b_next;
   logic [2:0]  flags_reg;
   logic [2:0]  flags_next;
   tmr8_dir_t   dir_reg;
   tmr8_dir_t   dir_next;
   logic        block_reg;
   logic        block_next;
   logic        osc_seen_reg;
   logic        osc_seen_next;
   logic        wr_pend_reg;
   logic        wr_pend_next;
   logic        rd_pend_reg;
   logic        rd_pend_next;
   logic [7:0]  addr_reg;
   logic [7:0]  addr_next;
   logic [31:0] hrdata_next;
   logic        hreadyout_next;

   logic        osc_sync;
   tmr8_mode_t  mode;
   logic        fast_pwm;
   logic        phase_pwm;
   logic        pwm;
   logic [7:0]  top_val;
   logic        tick;
   logic        at_top;
   logic        match_a;
   logic        match_b;
   logic        ovf_set;
   logic [2:0]  flag_clr;
   logic [7:0]  rd_val;

   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////////
   tmr8_sync2 u_osc_sync
   (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (timer_osc_in),
      .sync_out (osc_sync)
   );

   tmr8_wave_unit #(.IS_CHAN_A(1'b1)) u_wave_a
   (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .action     (ctrl_a_reg[TMR8_CHA_ACT_LSB +: 2]),
      .fast_pwm   (fast_pwm),
      .phase_pwm  (phase_pwm),
      .top_bit    (ctrl_b_reg[TMR8_WGM_TOP_BIT]),
      .match      (match_a),
      .at_top     (at_top),
      .cmp_is_top (cmp_a_reg == top_val),
      .count_up   (dir_reg == TMR8_DIR_UP),
      .wave_out   (channel_a_wave_out),
      .wave_oe    (channel_a_wave_oe)
   );

   tmr8_wave_unit #(.IS_CHAN_A(1'b0)) u_wave_b
   (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .action     (ctrl_a_reg[TMR8_CHB_ACT_LSB +: 2]),
      .fast_pwm   (fast_pwm),
      .phase_pwm  (phase_pwm),
      .top_bit    (ctrl_b_reg[TMR8_WGM_TOP_BIT]),
      .match      (match_b),
      .at_top     (at_top),
      .cmp_is_top (cmp_b_reg == top_val),
      .count_up   (dir_reg == TMR8_DIR_UP),
      .wave_out   (channel_b_wave_out),
      .wave_oe    (channel_b_wave_oe)
   );

   ////////////////////////////////////////////////////////////////////////////////////
   // mode decode, tick and compare events
   always_comb
   begin
      mode      = tmr8_mode_t'({ctrl_b_reg[TMR8_WGM_TOP_BIT],
                                ctrl_a_reg[TMR8_WGM_LOW_LSB +: 2]});
      fast_pwm  = (mode == TMR8_MODE_FAST_MAX) || (mode == TMR8_MODE_FAST_CMP);
      phase_pwm = (mode == TMR8_MODE_PC_MAX) || (mode == TMR8_MODE_PC_CMP);
      pwm       = fast_pwm || phase_pwm;
      // reserved modes 4 and 6 fall back to a plain free-running count
      if (mode == TMR8_MODE_CLR_CMP || mode == TMR8_MODE_PC_CMP || mode == TMR8_MODE_FAST_CMP)
         top_val = cmp_a_reg;
      else
         top_val = TMR8_MAX;
      // async: one tick per rising oscillator edge seen after the synchroniser
      tick      = ctrl_b_reg[TMR8_RUN_BIT]
                  && (!ctrl_b_reg[TMR8_ASYNC_BIT] || (osc_sync && !osc_seen_reg));
      at_top    = tick && (count_reg == top_val);
      // a counter write suppresses the match on the following tick
      match_a   = tick && (count_reg == cmp_a_reg) && !block_reg;
      match_b   = tick && (count_reg == cmp_b_reg) && !block_reg;
      if (phase_pwm)
         ovf_set = tick && (count_reg == TMR8_BOTTOM);
      else if (mode == TMR8_MODE_FAST_CMP)
         ovf_set = at_top;
      else
         ovf_set = tick && (count_reg == TMR8_MAX);
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // bus slave, registers and counter next state
   always_comb
   begin
      ctrl_a_next    = ctrl_a_reg;
      ctrl_b_next    = ctrl_b_reg;
      count_next     = count_reg;
      cmp_a_buf_next = cmp_a_buf_reg;
      cmp_b_buf_next = cmp_b_buf_reg;
      cmp_a_next     = cmp_a_reg;
      cmp_b_next     = cmp_b_reg;
      dir_next       = dir_reg;
      block_next     = tick ? 1'b0 : block_reg;
      osc_seen_next  = osc_sync;
      wr_pend_next   = 1'b0;
      rd_pend_next   = 1'b0;
      addr_next      = addr_reg;
      hrdata_next    = hrdata;
      hreadyout_next = hreadyout;
      flag_clr       = 3'h0;
      rd_val         = TMR8_RESET_8;

      // counting sequence per mode
      if (tick)
      begin
         if (fast_pwm)
            count_next = at_top ? TMR8_BOTTOM : 8'(count_reg + 8'h01);
         else if (phase_pwm)
         begin
            if (dir_reg == TMR8_DIR_UP)
            begin
               if (count_reg == top_val)
               begin
                  dir_next = TMR8_DIR_DOWN;
                  if (count_reg != TMR8_BOTTOM)
                     count_next = 8'(count_reg - 8'h01);
               end
               else
                  count_next = 8'(count_reg + 8'h01);
            end
            else if (count_reg == TMR8_BOTTOM)
            begin
               dir_next = TMR8_DIR_UP;
               if (top_val != TMR8_BOTTOM)
                  count_next = 8'(count_reg + 8'h01);
            end
            else
               count_next = 8'(count_reg - 8'h01);
         end
         else if (mode == TMR8_MODE_CLR_CMP)
            count_next = at_top ? TMR8_BOTTOM : 8'(count_reg + 8'h01);
         else
            count_next = 8'(count_reg + 8'h01);
      end
      if (!phase_pwm)
         dir_next = TMR8_DIR_UP;

      // data phase of a write
      if (wr_pend_reg)
      begin
         if (addr_reg == TMR8_OFS_CTRL_A)
            ctrl_a_next = hwdata[7:0] & TMR8_CTRL_A_WMASK;
         else if (addr_reg == TMR8_OFS_CTRL_B)
            ctrl_b_next = hwdata[7:0] & TMR8_CTRL_B_WMASK;
         else if (addr_reg == TMR8_OFS_COUNT)
         begin
            count_next = hwdata[7:0];
            block_next = 1'b1;
         end
         else if (addr_reg == TMR8_OFS_CMP_A)
            cmp_a_buf_next = hwdata[7:0];
         else if (addr_reg == TMR8_OFS_CMP_B)
            cmp_b_buf_next = hwdata[7:0];
         else if (addr_reg == TMR8_OFS_FLAGS)
            flag_clr = hwdata[2:0];
      end

      // compare values: straight through outside PWM, at TOP inside it
      if (!pwm || at_top)
      begin
         cmp_a_next = cmp_a_buf_next;
         cmp_b_next = cmp_b_buf_next;
      end

      // a hardware set in the same cycle as a clear wins
      flags_next = flags_reg & ~flag_clr;
      flags_next[TMR8_FLAG_OVF]     = flags_next[TMR8_FLAG_OVF] | ovf_set;
      flags_next[TMR8_FLAG_MATCH_A] = flags_next[TMR8_FLAG_MATCH_A] | match_a;
      flags_next[TMR8_FLAG_MATCH_B] = flags_next[TMR8_FLAG_MATCH_B] | match_b;

      // read wait state: data sampled one cycle late so a prior write is seen
      if (rd_pend_reg)
      begin
         if (addr_reg == TMR8_OFS_CTRL_A)
            rd_val = ctrl_a_reg & TMR8_CTRL_A_WMASK;
         else if (addr_reg == TMR8_OFS_CTRL_B)
            rd_val = ctrl_b_reg;
         else if (addr_reg == TMR8_OFS_COUNT)
            rd_val = count_reg;
         else if (addr_reg == TMR8_OFS_CMP_A)
            rd_val = cmp_a_buf_reg;
         else if (addr_reg == TMR8_OFS_CMP_B)
            rd_val = cmp_b_buf_reg;
         else if (addr_reg == TMR8_OFS_FLAGS)
            rd_val = {5'h00, flags_reg};
         hrdata_next    = {24'h000000, rd_val};
         hreadyout_next = 1'b1;
      end

      // address phase
      if (hsel && hready && htrans[1])
      begin
         addr_next = haddr[7:0];
         if (hwrite)
            wr_pend_next = (hsize == TMR8_HSIZE_WORD);
         else
         begin
            rd_pend_next   = 1'b1;
            hreadyout_next = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_a_reg    <= TMR8_RESET_8;
         ctrl_b_reg    <= TMR8_RESET_8;
         count_reg     <= TMR8_RESET_8;
         cmp_a_buf_reg <= TMR8_RESET_8;
         cmp_b_buf_reg <= TMR8_RESET_8;
         cmp_a_reg     <= TMR8_RESET_8;
         cmp_b_reg     <= TMR8_RESET_8;
         flags_reg     <= 3'h0;
         dir_reg       <= TMR8_DIR_UP;
         block_reg     <= 1'b0;
         osc_seen_reg  <= 1'b0;
         wr_pend_reg   <= 1'b0;
         rd_pend_reg   <= 1'b0;
         addr_reg      <= 8'h00;
         hrdata        <= 32'h00000000;
         hreadyout     <= 1'b1;
      end
      else
      begin
         ctrl_a_reg    <= ctrl_a_next;
         ctrl_b_reg    <= ctrl_b_next;
         count_reg     <= count_next;
         cmp_a_buf_reg <= cmp_a_buf_next;
         cmp_b_buf_reg <= cmp_b_buf_next;
         cmp_a_reg     <= cmp_a_next;
         cmp_b_reg     <= cmp_b_next;
         flags_reg     <= flags_next;
         dir_reg       <= dir_next;
         block_reg     <= block_next;
         osc_seen_reg  <= osc_seen_next;
         wr_pend_reg   <= wr_pend_next;
         rd_pend_reg   <= rd_pend_next;
         addr_reg      <= addr_next;
         hrdata        <= hrdata_next;
         hreadyout     <= hreadyout_next;
      end
   end
endmodule // tmr8_top
`default_nettype wire

// [logic/tmr8_wave_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr8_wave_unit
   import tmr8_pkg::*;
#(
   parameter bit IS_CHAN_A = 1'b1
)
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [1:0] action,
   input  wire logic       fast_pwm,
   input  wire logic       phase_pwm,
   input  wire logic       top_bit,
   input  wire logic       match,
   input  wire logic       at_top,
   input  wire logic       cmp_is_top,
   input  wire logic       count_up,
   output var  logic       wave_out,
   output var  logic       wave_oe
);
   logic wave_next;
   logic oe_next;
   logic pwm;
   logic toggle_ok;
   logic special;

   always_comb
   begin
      pwm       = fast_pwm | phase_pwm;
      // channel B has no toggle in PWM; A needs the top mode bit
      toggle_ok = !pwm || (top_bit && IS_CHAN_A);
      oe_next   = (action != TMR8_ACT_OFF)
                  && !(action == TMR8_ACT_TOGGLE && !toggle_ok);
      special   = pwm && action[1] && cmp_is_top;
      wave_next = wave_out;
      if (action == TMR8_ACT_TOGGLE)
      begin
         if (match && toggle_ok)
            wave_next = ~wave_out;
      end
      else if (action[1])
      begin
         if (special)
         begin
            // the match is dropped; the TOP action alone keeps a constant level
            if (at_top)
               wave_next = ~action[0];
         end
         else if (!pwm)
         begin
            if (match)
               wave_next = action[0];
         end
         else if (fast_pwm)
         begin
            if (match)
               wave_next = action[0];
            else if (at_top)
               wave_next = ~action[0];
         end
         else if (match)
            wave_next = count_up ? action[0] : ~action[0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wave_out <= 1'b0;
         wave_oe  <= 1'b0;
      end
      else
      begin
         wave_out <= wave_next;
         wave_oe  <= oe_next;
      end
   end
endmodule // tmr8_wave_unit
`default_nettype wire

// [test/tmr8_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr8_load_model
(
   input  wire logic drive,
   input  wire logic level,
   output var  logic pin
);
   // load has a pull-down, so a released pin reads low, never its last level
   assign pin = drive ? level : 1'b0;
endmodule // tmr8_load_model
`default_nettype wire

// [test/tmr8_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr8_top_sva
   import tmr8_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        timer_osc_in,
   input wire logic        channel_a_wave_out,
   input wire logic        channel_a_wave_oe,
   input wire logic        channel_b_wave_out,
   input wire logic        channel_b_wave_oe
);
   logic       dp_v_reg;
   logic       dp_w_reg;
   logic       dp_word_reg;
   logic [7:0] dp_a_reg;
   logic [7:0] ctl_a_reg;
   logic [7:0] ctl_b_reg;
   logic       taken;
   logic       commit;
   logic       rd_end;
   logic       quiet;
   assign taken  = hsel && hready && htrans[1];
   assign commit = dp_v_reg && dp_w_reg && dp_word_reg && hready;
   assign rd_end = dp_v_reg && !dp_w_reg && hreadyout;
   // no tick source and no register write pending
   assign quiet  = !ctl_b_reg[0] && !ctl_b_reg[1] && !(dp_v_reg && dp_w_reg);
   ////////////////////////////////////////////////////////////////////////////
   // shadow of the two control registers, rebuilt from bus traffic
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_v_reg    <= 1'b0;
         dp_w_reg    <= 1'b0;
         dp_word_reg <= 1'b0;
         dp_a_reg    <= 8'h00;
         ctl_a_reg   <= 8'h00;
         ctl_b_reg   <= 8'h00;
      end
      else
      begin
         if (commit && dp_a_reg == TMR8_OFS_CTRL_A)
            ctl_a_reg <= hwdata[7:0] & TMR8_CTRL_A_WMASK;
         if (commit && dp_a_reg == TMR8_OFS_CTRL_B)
            ctl_b_reg <= hwdata[7:0] & TMR8_CTRL_B_WMASK;
         dp_v_reg <= taken ? 1'b1 : (hready ? 1'b0 : dp_v_reg);
         if (taken)
         begin
            dp_w_reg    <= hwrite;
            dp_word_reg <= (hsize == TMR8_HSIZE_WORD);
            dp_a_reg    <= haddr[7:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
   read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   // a read taken in the write's data phase may legally stall the cycle after it
   write_nowait_a: assert property (taken && hwrite |=>
      hreadyout ##1 (hreadyout || $past(taken && !hwrite)))
      else $error("write stalled");
   rdata_upper_a: assert property (rd_end |-> hrdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   rsvd_read_a: assert property (
      rd_end && dp_a_reg == TMR8_OFS_CTRL_A |-> hrdata[3:2] == 2'h0)
      else $error("reserved bits read back nonzero");
   a_off_a: assert property ((ctl_a_reg[7:6] == 2'h0) [*3] |-> !channel_a_wave_oe)
      else $error("pin a driven while disconnected");
   b_off_a: assert property ((ctl_a_reg[5:4] == 2'h0) [*3] |-> !channel_b_wave_oe)
      else $error("pin b driven while disconnected");
   a_on_a: assert property (
      (ctl_a_reg[7:6] != 2'h0 && !ctl_a_reg[0]) [*3] |-> channel_a_wave_oe)
      else $error("pin a not driven");
   b_on_a: assert property (
      (ctl_a_reg[5:4] != 2'h0 && !ctl_a_reg[0]) [*3] |-> channel_b_wave_oe)
      else $error("pin b not driven");
   quiet_hold_a: assert property (quiet [*3] |-> $stable(channel_a_wave_out))
      else $error("wave a moved without a tick");
endmodule // tmr8_top_sva
`default_nettype wire

// [test/tmr8_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tmr8_top_tb
   import tmr8_pkg::*;
;
   logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, osc = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = TMR8_HSIZE_WORD;
   logic        hreadyout, hresp, wa_o, wa_e, wb_o, wb_e, pa, pb;
   int err_total = 0, num_checks = 0, seed = 49, cyc = 0;
   int cnt, dir, fl, ca, cb, wa, wb, md, aa, ab;
   // reserved modes 4 and 6 are run too: they must count like normal mode
   int modes[8] = '{0, 1, 2, 3, 4, 5, 6, 7};
   tmr8_top tmr8_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timer_osc_in(osc),
      .channel_a_wave_out(wa_o), .channel_a_wave_oe(wa_e),
      .channel_b_wave_out(wb_o), .channel_b_wave_oe(wb_e));
   tmr8_load_model load_a_i (.drive(wa_e), .level(wa_o), .pin(pa));
   tmr8_load_model load_b_i (.drive(wb_e), .level(wb_o), .pin(pb));
   initial forever #2.5 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         err_total++;
         print_verdict;
      end
   end
   task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task chk_pin(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
         err_total++;
      end
   endtask
   task ahb_go(input logic [7:0] a, input logic w);
      @(posedge hclk);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
   endtask
   task ahb_wr(input logic [7:0] a, input logic [31:0] d);
      ahb_go(a, 1'b1);
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      ahb_go(a, 1'b0);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      chk_reg(nm, e, hrdata);
   endtask
   task do_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      {cnt, dir, fl, wa, wb} = '0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   function automatic int wave(int w, int act, bit mt, bit tp, bit pwm, bit ph, int dn, bit tog);
      if (act == 1)
         return (mt && (!pwm || tog)) ? !w : w;
      if (act == 0)
         return w;
      if (mt)
         w = (act == 3) ^ (ph && dn == 1);
      if (tp)
         w = (act == 2);
      return w;
   endfunction
   // one oscillator pulse is one tick; compare values are never rewritten in pwm modes
   task step;
      int top;
      bit pwm, ph, fast, sa, sb, ea, eb;
      @(posedge hclk);
      osc <= 1'b1;
      repeat (4) @(posedge hclk);
      osc <= 1'b0;
      repeat (4) @(posedge hclk);
      pwm = md[0];
      ph = (md % 4 == 1);
      fast = (md % 4 == 3);
      top = (md == 2 || md == 5 || md == 7) ? ca : 255;
      sa = pwm && ca == top && aa >= 2;
      sb = pwm && cb == top && ab >= 2;
      if (cnt == ca) fl |= 2;
      if (cnt == cb) fl |= 4;
      if (ph ? cnt == 0 : cnt == top && (md == 7 || cnt == 255)) fl |= 1;
      wa = wave(wa, aa, cnt == ca && !sa, cnt == top && (fast || sa), pwm, ph, dir, md >= 4);
      wb = wave(wb, ab, cnt == cb && !sb, cnt == top && (fast || sb), pwm, ph, dir, 1'b0);
      if (ph && dir == 0 && cnt == top) {dir, cnt} = {32'd1, top - 1};
      else if (ph && dir == 1 && cnt == 0) {dir, cnt} = {32'd0, 32'd1};
      else if (ph) cnt = dir ? cnt - 1 : cnt + 1;
      else cnt = (cnt == top) ? 0 : (cnt + 1) % 256;
      rd_chk("count", TMR8_OFS_COUNT, cnt);
      rd_chk("flags", TMR8_OFS_FLAGS, fl);
      ea = aa != 0 && !(pwm && aa == 1 && md < 4);
      eb = ab != 0 && !(pwm && ab == 1);
      chk_pin("oe_a", ea, wa_e);
      chk_pin("oe_b", eb, wb_e);
      chk_pin("pin_a", ea && wa[0], pa);
      chk_pin("pin_b", eb && wb[0], pb);
      ahb_wr(TMR8_OFS_FLAGS, 32'h00000007);
      fl = 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      do_reset;
      for (int o = 0; o <= 8'h18; o += 4)
         rd_chk("reset_reg", o, 32'h00000000);
      ahb_wr(TMR8_OFS_CTRL_A, 32'hFFFFFFFF);
      rd_chk("ctrl_a", TMR8_OFS_CTRL_A, 32'h000000F3);
      ahb_wr(TMR8_OFS_CTRL_B, 32'hFFFFFFFF);
      rd_chk("ctrl_b", TMR8_OFS_CTRL_B, 32'h0000000B);
      $display("test registers done");
      for (int i = 0; i < 8; i++)
         for (int a = 1; a <= 3; a++)
         begin
            do_reset;
            md = modes[i];
            aa = a;
            ab = 4 - a;
            if (md == 2 || md >= 5)
            begin
               ca = 8'h10 + $unsigned($random(seed)) % 8;
               cb = 8'h04 + $unsigned($random(seed)) % 8;
               cnt = 0;
            end
            else
            begin
               ca = (a == 2 && md % 2 == 1) ? 255 : 8'hF0 + $unsigned($random(seed)) % 8;
               cb = 8'hF0 + $unsigned($random(seed)) % 8;
               cnt = 8'hE0;
            end
            ahb_wr(TMR8_OFS_CMP_A, ca);
            ahb_wr(TMR8_OFS_CMP_B, cb);
            ahb_wr(TMR8_OFS_COUNT, cnt);
            ahb_wr(TMR8_OFS_CTRL_A, (aa << 6) | (ab << 4) | (md % 4));
            ahb_wr(TMR8_OFS_CTRL_B, ((md / 4) << 3) | 3);
            repeat (60) step;
            $display("test mode %0d action %0d done", md, aa);
         end
      print_verdict;
   end
endmodule // tmr8_top_tb
bind tmr8_top tmr8_top_sva tmr8_top_sva_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .timer_osc_in(timer_osc_in), .channel_a_wave_out(channel_a_wave_out),
   .channel_a_wave_oe(channel_a_wave_oe), .channel_b_wave_out(channel_b_wave_out),
   .channel_b_wave_oe(channel_b_wave_oe));
`default_nettype wire
